// file: bench/scc_peer.sv
// Purpose: far-side serial device model
// Assumes: select active low, data sampled on rising serial clock
// Notes: pull-up on the select line
`timescale 1ns/1ns
module scc_peer (
  input wire logic sck_i,
  input wire logic data_i,
  input wire logic sel_i,
  input wire logic sel_oe_i,
  input wire logic [7:0] reply_i,
  output logic data_o,
  output logic sel_o,
  output logic [7:0] got_o
);
  logic act;
  logic [7:0] sh;
  assign sel_o = sel_oe_i ? sel_i : 1'b1;
  assign act = (sel_oe_i === 1'b1) && (sel_i === 1'b0);
  // released line shows the inverse of its last bit
  assign data_o = act ? sh[7] : ~sh[7];
  initial begin
    sh = 8'h00;
    got_o = 8'h00;
  end
  always @(posedge act) begin
    sh = reply_i;
  end
  always @(posedge sck_i) begin
    if (act) begin
      got_o = {got_o[6:0], data_i};
    end
  end
  always @(negedge sck_i) begin
    if (act) begin
      sh = {sh[6:0], 1'b0};
    end
  end
endmodule : scc_peer

// file: bench/tb.sv
// Purpose: self-checking bench of the serial control block
// Assumes: classic wishbone, 50 MHz clock, sync reset
// Notes: reads are checked by a monitor against a queue
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack, idle, sck, sck_oe, sdo, sdo_oe, sel_o, sel_oe, sel_w;
  logic sdi, bcs, deep;
  logic [7:0] reply = 8'h00;
  logic reference_clock = 1'b0;
  logic [7:0] got;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int checks = 0;
  always #10 clk = ~clk;
  // reference clock at half the bus clock rate
  always @(posedge clk) reference_clock <= ~reference_clock;
  initial idle = 1'b0;
  scc_ctrl #(.HALF_DIV(16'h0004)) u_scc_ctrl (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .idle_mode_i(idle), .reference_clock_i(reference_clock), .serial_in_i(sdi),
    .select_pin_i(sel_w), .select_pin_o(sel_o), .select_pin_oe_o(sel_oe),
    .serial_out_pin_o(sdo), .serial_out_pin_oe_o(sdo_oe), .sck_o(sck),
    .sck_oe_o(sck_oe), .baud_clock_select_o(bcs),
    .deep_buffer_enable_o(deep));
  scc_peer u_scc_peer (.sck_i(sck), .data_i(sdo), .sel_i(sel_o),
    .sel_oe_i(sel_oe), .reply_i(reply), .data_o(sdi), .sel_o(sel_w),
    .got_o(got));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // read monitor: oldest note against returned data
  always @(posedge clk) begin
    if (ack === 1'b1 && cyc && !we) begin
      chk("wb_dat_o", exp_q.pop_front(), rdat);
    end
  end
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk("ack wait", 32'h0000_0001, 32'h0000_0000);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  // wait for the select line to reach the given active state
  task automatic wsel(input logic lvl);
    int n;
    n = 0;
    while ((sel_oe === 1'b1 && sel_o === 1'b0) !== lvl && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n == 2000) chk("select wait", {31'h0, lvl}, {31'h0, ~lvl});
  endtask : wsel
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    #(40000 * 20);
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(98));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(scc_pkg::ADR_CTRL, scc_pkg::CTRL_RST);
    bus(1'b1, scc_pkg::ADR_CTRL, 32'hFFFF_FFFF);
    rd(scc_pkg::ADR_CTRL, 32'hFF83_BFFF);
    chk("baud sel", 32'h0000_0001, {31'h0, bcs});
    chk("deep buf", 32'h0000_0001, {31'h0, deep});
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h0000_0000);
    rd(scc_pkg::ADR_CTRL, scc_pkg::CTRL_LOCK);
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h0000_0000);
    rd(scc_pkg::ADR_CTRL, 32'h0000_0000);
    chk("baud sel off", 32'h0000_0000, {31'h0, bcs});
    $display("test registers done");
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h0000_0200);
    rd(scc_pkg::ADR_CTRL, 32'h0000_0000);
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h0000_0220);
    rd(scc_pkg::ADR_CTRL, 32'h0000_0220);
    rd(8'h10, 32'h0000_0000);
    $display("test sample phase done");
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h1000_8120);
    chk("sck oe", 32'h0000_0001, {31'h0, sck_oe});
    chk("sdo oe", 32'h0000_0001, {31'h0, sdo_oe});
    reply = 8'($urandom);
    bus(1'b1, scc_pkg::ADR_DATA, {24'h00_0000, 8'($urandom)});
    wsel(1'b1);
    wsel(1'b0);
    chk("peer byte", {24'h00_0000, wdat[7:0]}, {24'h00_0000, got});
    rd(scc_pkg::ADR_DATA, {24'h00_0000, reply});
    $display("test transfer done");
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h1000_9120);
    chk("sdo released", 32'h0000_0000, {31'h0, sdo_oe});
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h1000_A120);
    idle <= 1'b1;
    bus(1'b1, scc_pkg::ADR_DATA, 32'h0000_00A5);
    repeat (100) @(posedge clk);
    chk("idle halt", 32'h0000_0000, {31'h0, sel_oe & ~sel_o});
    idle <= 1'b0;
    wsel(1'b1);
    wsel(1'b0);
    chk("idle byte", 32'h0000_00A5, {24'h00_0000, got});
    $display("test idle stop done");
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h0000_0000);
    bus(1'b1, scc_pkg::ADR_CTRL2, 32'h0000_0080);
    rd(scc_pkg::ADR_CTRL2, 32'h0000_0080);
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h1080_8820);
    chk("ref sel", 32'h0000_0001, {31'h0, bcs});
    chk("audio idle", 32'h0000_0001, {31'h0, sck});
    bus(1'b1, scc_pkg::ADR_DATA, {24'h00_0000, 8'($urandom)});
    wsel(1'b1);
    wsel(1'b0);
    chk("audio byte", {24'h00_0000, wdat[7:0]}, {24'h00_0000, got});
    $display("test audio done");
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h0000_0000);
    bus(1'b1, scc_pkg::ADR_CTRL2, 32'h0000_0000);
    bus(1'b1, scc_pkg::ADR_CTRL, 32'h8000_8020);
    bus(1'b1, scc_pkg::ADR_DATA, 32'h0000_005A);
    wsel(1'b1);
    wsel(1'b0);
    rd(scc_pkg::ADR_CTRL, 32'h8000_8020);
    $display("test framed done");
    results();
  end
endmodule : tb

// file: src/scc_ctrl.sv
// Purpose: control register and serial engine of the serial unit
// Assumes: classic wishbone slave, one clock, sync reset
// Notes: controller role drives the engine; target role drives no clock or data, only an inactive select in framed output
`timescale 1ns/1ns
module scc_ctrl #(
  parameter logic [15:0] HALF_DIV = scc_pkg::HALF_DIV_RST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic idle_mode_i,
  input wire logic reference_clock_i,
  input wire logic serial_in_i,
  input wire logic select_pin_i,
  output logic select_pin_o,
  output logic select_pin_oe_o,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  output logic sck_o,
  output logic sck_oe_o,
  output logic baud_clock_select_o,
  output logic deep_buffer_enable_o
);
  if (HALF_DIV == 16'h0000) begin : g_chk
    $error("HALF_DIV must be at least one");
  end

  scc_pkg::scc_state_s s_ff;
  scc_pkg::scc_state_s nxt_s;

  logic en;
  logic ctl;
  logic frm;
  logic fin;
  logic fout;
  logic pol;
  logic cpol;
  logic cke;
  logic input_sample_phase;
  logic halt;
  logic w32;
  logic w16;
  logic [5:0] dbits;
  logic [5:0] cbits;
  logic [2:0] cntc;
  logic [5:0] pw;
  logic [4:0] cmask;
  logic sync_chr;
  logic tick_src;
  logic in_sh;
  logic in_lead;
  logic pon;
  logic asel;
  logic req;
  logic [31:0] wm;
  logic [31:0] rx_in;

  assign en = s_ff.ctrl[scc_pkg::B_ON];
  assign ctl = s_ff.ctrl[scc_pkg::B_CTL];
  assign frm = s_ff.ctrl[scc_pkg::B_FRM];
  assign fin = frm & s_ff.ctrl[scc_pkg::B_DIR];
  assign fout = frm & ~s_ff.ctrl[scc_pkg::B_DIR];
  assign pol = s_ff.ctrl[scc_pkg::B_POL];
  assign cpol = s_ff.aud | s_ff.ctrl[scc_pkg::B_CKP];
  assign cke = s_ff.ctrl[scc_pkg::B_CKE] & ~frm;
  assign input_sample_phase = s_ff.ctrl[scc_pkg::B_SMP] & ctl;
  assign halt = s_ff.ctrl[scc_pkg::B_IDLE] & idle_mode_i;
  assign w32 = s_ff.ctrl[scc_pkg::B_W32];
  assign w16 = s_ff.ctrl[scc_pkg::B_W16];

  // data and channel lengths
  always_comb begin
    if (s_ff.aud) begin
      if (w32 & w16) begin
        dbits = 6'd24;
      end else if (w32) begin
        dbits = 6'd32;
      end else begin
        dbits = 6'd16;
      end
      cbits = (w32 | w16) ? 6'd32 : 6'd16;
    end else begin
      if (w32) begin
        dbits = 6'd32;
      end else if (w16) begin
        dbits = 6'd16;
      end else begin
        dbits = 6'd8;
      end
      cbits = dbits;
    end
  end

  // characters per sync pulse, reserved codes clamp to 32
  assign cntc = (s_ff.ctrl[26:24] > 3'd5) ? 3'd5 : s_ff.ctrl[26:24];
  assign pw = 6'h01 << cntc;
  assign cmask = pw[4:0] - 5'h01;
  assign sync_chr = (s_ff.chr == 5'h00);

  assign tick_src = s_ff.ctrl[scc_pkg::B_BCS] ?
                    (s_ff.ref_s[1] & ~s_ff.ref_p) : 1'b1;
  assign in_sh = (s_ff.st == scc_pkg::SCC_SHIFT);
  assign in_lead = (s_ff.st == scc_pkg::SCC_LEAD);

  // generated frame-sync pulse
  always_comb begin
    if (s_ff.ctrl[scc_pkg::B_SPW]) begin
      if (s_ff.ctrl[scc_pkg::B_EDGE]) begin
        pon = in_sh;
      end else begin
        pon = in_lead | (in_sh & (s_ff.bits < cbits - 6'd1));
      end
    end else begin
      if (s_ff.ctrl[scc_pkg::B_EDGE]) begin
        pon = in_sh & (s_ff.bits == 6'd0);
      end else begin
        pon = in_lead;
      end
    end
    pon = pon & fout & sync_chr;
  end

  assign asel = ctl & s_ff.ctrl[scc_pkg::B_ASEL] & ~frm;
  assign req = wb_cyc_i & wb_stb_i;
  assign wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign rx_in = {s_ff.rx[30:0], s_ff.sin_s[1]};

  always_comb begin
    logic [31:0] v;
    logic ht;
    v = '0;
    ht = 1'b0;
    nxt_s = s_ff;
    nxt_s.ref_s = {s_ff.ref_s[0], reference_clock_i};
    nxt_s.ref_p = s_ff.ref_s[1];
    nxt_s.sin_s = {s_ff.sin_s[0], serial_in_i};
    nxt_s.sel_s = {s_ff.sel_s[0], select_pin_i};
    // half-bit tick
    if (en & ~halt & tick_src & (s_ff.st != scc_pkg::SCC_IDLE)) begin
      if (s_ff.div == HALF_DIV - 16'h0001) begin
        nxt_s.div = 16'h0000;
        ht = 1'b1;
      end else begin
        nxt_s.div = s_ff.div + 16'h0001;
      end
    end
    // engine
    if (!en) begin
      nxt_s.st = scc_pkg::SCC_IDLE;
      nxt_s.chr = 5'h00;
      nxt_s.div = 16'h0000;
      nxt_s.half = 1'b0;
    end else if (!halt) begin
      case (s_ff.st)
        scc_pkg::SCC_IDLE: begin
          if (s_ff.go & ctl & ~fin) begin
            nxt_s.go = 1'b0;
            nxt_s.sh = s_ff.tx << (6'd32 - dbits);
            nxt_s.bits = 6'd0;
            nxt_s.half = 1'b0;
            nxt_s.div = 16'h0000;
            if (fout & sync_chr & ~s_ff.ctrl[scc_pkg::B_EDGE]) begin
              nxt_s.st = scc_pkg::SCC_LEAD;
            end else begin
              nxt_s.st = scc_pkg::SCC_SHIFT;
            end
          end
        end
        scc_pkg::SCC_LEAD: begin
          if (ht) begin
            nxt_s.half = ~s_ff.half;
            if (s_ff.half) begin
              nxt_s.st = scc_pkg::SCC_SHIFT;
            end
          end
        end
        scc_pkg::SCC_SHIFT: begin
          if (ht & ~s_ff.half) begin
            nxt_s.half = 1'b1;
            if (!input_sample_phase) begin
              nxt_s.rx = rx_in;
            end
          end else if (ht) begin
            nxt_s.half = 1'b0;
            if (input_sample_phase) begin
              nxt_s.rx = rx_in;
            end
            nxt_s.sh = s_ff.sh << 1;
            nxt_s.bits = s_ff.bits + 6'd1;
            if (s_ff.bits == cbits - 6'd1) begin
              nxt_s.st = scc_pkg::SCC_IDLE;
              nxt_s.rxd = input_sample_phase ? rx_in : s_ff.rx;
              nxt_s.chr = (s_ff.chr + 5'h01) & cmask;
            end
          end
        end
        default: begin
          nxt_s.st = scc_pkg::SCC_IDLE;
        end
      endcase
    end
    // wishbone slave: answer one cycle after the request
    nxt_s.ack = req & ~s_ff.ack;
    if (req & ~s_ff.ack) begin
      case (wb_adr_i)
        scc_pkg::ADR_CTRL: nxt_s.dat = s_ff.ctrl & scc_pkg::CTRL_IMPL;
        scc_pkg::ADR_CTRL2: nxt_s.dat = {24'h00_0000, s_ff.aud, 7'h00};
        scc_pkg::ADR_DATA: nxt_s.dat = s_ff.rxd;
        scc_pkg::ADR_STAT: begin
          nxt_s.dat = 32'h0000_0000;
          nxt_s.dat[scc_pkg::S_BUSY] =
            (s_ff.st != scc_pkg::SCC_IDLE) | s_ff.go;
          nxt_s.dat[scc_pkg::S_SEL] = (s_ff.sel_s[1] == pol);
        end
        default: nxt_s.dat = 32'h0000_0000;
      endcase
    end
    // writes take effect at the acknowledging edge
    if (req & s_ff.ack & wb_we_i) begin
      case (wb_adr_i)
        scc_pkg::ADR_CTRL: begin
          v = (s_ff.ctrl & ~wm) | (wb_dat_i & wm);
          v = v & scc_pkg::CTRL_IMPL;
          if (en) begin
            v = (v & ~scc_pkg::CTRL_LOCK) |
                (s_ff.ctrl & scc_pkg::CTRL_LOCK);
          end
          v[scc_pkg::B_SMP] = v[scc_pkg::B_SMP] & (ctl | v[scc_pkg::B_CTL]);
          nxt_s.ctrl = v;
        end
        scc_pkg::ADR_CTRL2: begin
          if (wb_sel_i[0] & ~en) begin
            nxt_s.aud = wb_dat_i[scc_pkg::B_AUD];
          end
        end
        scc_pkg::ADR_DATA: begin
          nxt_s.tx = (s_ff.tx & ~wm) | (wb_dat_i & wm);
          nxt_s.go = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.ctrl <= scc_pkg::CTRL_RST;
      s_ff.st <= scc_pkg::SCC_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign wb_ack_o = s_ff.ack;
  assign wb_dat_o = s_ff.dat;
  assign sck_o = cpol ^ (in_sh & (cke ? s_ff.half : ~s_ff.half));
  assign sck_oe_o = en & ctl;
  assign serial_out_pin_o = s_ff.sh[31];
  assign serial_out_pin_oe_o = en & ctl & ~s_ff.ctrl[scc_pkg::B_REL];
  assign select_pin_o = (fout ? pon : (asel & (in_sh | in_lead))) ?
                        pol : ~pol;
  assign select_pin_oe_o = en & (fout | asel);
  assign baud_clock_select_o = s_ff.ctrl[scc_pkg::B_BCS];
  assign deep_buffer_enable_o = s_ff.ctrl[scc_pkg::B_DEEP];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reserved_read: assert property (
    s_ff.ack && wb_adr_i == scc_pkg::ADR_CTRL && !wb_we_i
    |-> (wb_dat_o & ~scc_pkg::CTRL_IMPL) == 32'h0000_0000)
    else $error("unimplemented control bit read as one");
  a_lock_source: assert property (
    en |=> s_ff.ctrl[scc_pkg::B_BCS] == $past(s_ff.ctrl[scc_pkg::B_BCS])
           && s_ff.ctrl[scc_pkg::B_DEEP] == $past(s_ff.ctrl[scc_pkg::B_DEEP]))
    else $error("locked bit changed while enabled");
  a_audio_polarity: assert property (
    s_ff.aud && !in_sh |-> sck_o)
    else $error("clock not idle high in audio mode");
  a_idle_level: assert property (
    !s_ff.aud && !in_sh |-> sck_o == s_ff.ctrl[scc_pkg::B_CKP])
    else $error("clock idle level wrong");
  a_out_release: assert property (
    s_ff.ctrl[scc_pkg::B_REL] |-> !serial_out_pin_oe_o)
    else $error("data pin driven while released");
  a_off_clears: assert property (
    !en |=> s_ff.st == scc_pkg::SCC_IDLE && s_ff.chr == 5'h00)
    else $error("engine or counter not cleared while off");
  a_auto_select: assert property (
    en && asel && in_sh |-> select_pin_oe_o && select_pin_o == pol)
    else $error("select not active during transfer");
  a_sync_input: assert property (
    en && fin |-> !select_pin_oe_o)
    else $error("sync pin driven in input direction");
  a_lead_pulse: assert property (
    in_lead |-> select_pin_o == pol ##1 (in_lead || in_sh))
    else $error("leading sync pulse wrong");
  a_idle_halt: assert property (
    en && halt |=> $stable(s_ff.st) && $stable(s_ff.bits))
    else $error("engine moved during idle stop");
  a_word_len: assert property (
    in_sh |-> s_ff.bits < cbits)
    else $error("bit count past word length");

  c_framed_lead: cover property (in_lead ##1 in_sh);
  c_audio_end: cover property (s_ff.aud && in_sh ##1 !in_sh);
  c_ref_source: cover property (s_ff.ctrl[scc_pkg::B_BCS] && in_sh);
endmodule : scc_ctrl

// file: src/scc_pkg.sv
// Purpose: constants and types of the serial control block
// Assumes: 32-bit classic wishbone register access
// Notes: offsets are byte addresses
package scc_pkg;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CTRL2 = 8'h04;
  localparam logic [7:0] ADR_DATA = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_IMPL = 32'hFF83_BFFF;
  localparam logic [31:0] CTRL_LOCK = 32'h0081_0000;
  localparam int B_FRM = 31;
  localparam int B_DIR = 30;
  localparam int B_POL = 29;
  localparam int B_ASEL = 28;
  localparam int B_SPW = 27;
  localparam int B_CNT = 24;
  localparam int B_BCS = 23;
  localparam int B_EDGE = 17;
  localparam int B_DEEP = 16;
  localparam int B_ON = 15;
  localparam int B_IDLE = 13;
  localparam int B_REL = 12;
  localparam int B_W32 = 11;
  localparam int B_W16 = 10;
  localparam int B_SMP = 9;
  localparam int B_CKE = 8;
  localparam int B_CKP = 6;
  localparam int B_CTL = 5;
  localparam int B_AUD = 7;
  localparam int S_BUSY = 0;
  localparam int S_SEL = 1;
  localparam logic [15:0] HALF_DIV_RST = 16'h0004;

  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_LEAD = 2'b01,
    SCC_SHIFT = 2'b10
  } scc_state_e;

  typedef struct packed {
    logic [31:0] ctrl;
    logic aud;
    logic [31:0] tx;
    logic go;
    logic [31:0] sh;
    logic [31:0] rx;
    logic [31:0] rxd;
    scc_state_e st;
    logic [5:0] bits;
    logic half;
    logic [4:0] chr;
    logic [15:0] div;
    logic [1:0] ref_s;
    logic ref_p;
    logic [1:0] sin_s;
    logic [1:0] sel_s;
    logic ack;
    logic [31:0] dat;
  } scc_state_s;
endpackage : scc_pkg
